// ### src/ddrmb_map.svh
`ifndef DDRMB_MAP_SVH
`define DDRMB_MAP_SVH

// positions inside the synchronised pin vector
`define DDRMB_SY_RSTN   0
`define DDRMB_SY_CSN    1
`define DDRMB_SY_CKP    2
`define DDRMB_SY_CKN    3
`define DDRMB_SY_PSCP   4
`define DDRMB_SY_PSCN   5
`define DDRMB_SY_RW_DATA_STROBE   6
`define DDRMB_SY_DQ     7
`define DDRMB_SY_W      15
// reset value of the pin vector: reset and chip select idle high
`define DDRMB_SY_INIT   15'h0003

// command-address phase: six bytes, read flag in the top bit
`define DDRMB_CA_BYTES  3'd6
`define DDRMB_CA_RD_BIT 47

// default latency count, in bus clock rising edges, before doubling
`define DDRMB_LAT_CLKS  6
`define DDRMB_FIFO_DEPTH 4
`define DDRMB_MEM_BYTES 16

`endif

// ### src/ddrmb_pkg.sv
package ddrmb_pkg;

  // transaction phases seen on the bus
  typedef enum logic [2:0]
  {
    DDRMB_IDLE,
    DDRMB_CA,
    DDRMB_LAT,
    DDRMB_RD,
    DDRMB_WR,
    DDRMB_DONE
  } ddrmb_state_t;

endpackage : ddrmb_pkg

// ### src/ddrmb_fifo.sv
module ddrmb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  ////////////////////////////////////////////////////////////////////////////
  // full and empty come straight from the occupancy count
  assign in_ready  = (count_q != (AW + 1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data  = mem_q[rd_ptr_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage has no reset: only entries below the count are ever read
  always_ff @(posedge ref_clk)
  begin
    if (ce && push)
    begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // pointers wrap at depth, so depth need not be a power of two
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end
    else if (ce)
    begin
      if (flush)
      begin
        wr_ptr_q <= '0;
        rd_ptr_q <= '0;
        count_q  <= '0;
      end
      else
      begin
        if (push)
        begin
          wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
        end
        if (pop)
        begin
          rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
        end
        count_q <= count_q + (AW + 1)'(push) - (AW + 1)'(pop);
      end
    end
  end

endmodule : ddrmb_fifo

// ### src/ddrmb_device.sv
// Operation
// - with centre-aligned option on, strobe edges follow the shifted clock.
// - shifted clock pair is ignored during writes; host holds it static.
// - differential mode uses both shifted lines, otherwise only true line.
// - chip select falling starts a transaction, rising ends it.
// - bytes reference clock crossings; single-ended mode ignores complement.
// - bus clock may stop or be gated; nothing needs a running clock.
// - reads: device drives strobe with data; writes: host strobe masks bytes.
// - strobe is driven at every transaction start to flag extra latency.
// - stacked device always signals and uses doubled initial latency.
// - command-address and data bytes share the eight-bit data bus.
// - hardware reset low: go idle, float strobe and data lines.
`include "ddrmb_map.svh"

module ddrmb_device
  import ddrmb_pkg::*;
#(
  parameter int LAT_CLKS  = `DDRMB_LAT_CLKS,
  parameter int MEM_BYTES = `DDRMB_MEM_BYTES,
  parameter int FIFO_DEPTH = `DDRMB_FIFO_DEPTH
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       diff_clk_mode,
  input  wire logic       center_aligned_read_strobe,
  input  wire logic       hw_reset_n,
  input  wire logic       cs_n,
  input  wire logic       bus_clk_p,
  input  wire logic       bus_clk_n,
  input  wire logic       shifted_clk_p,
  input  wire logic       shifted_clk_n,
  input  wire logic [7:0] dq_in,
  output logic      [7:0] dq_out,
  output logic            dq_oe_n,
  input  wire logic       rw_data_strobe_in,
  output logic            rw_data_strobe_out,
  output logic            rw_data_strobe_oe_n
);

  localparam int AW = $clog2(MEM_BYTES);
  localparam int LAT_TOTAL = 2 * LAT_CLKS;
  localparam int LW = $clog2(LAT_TOTAL + 1);

  logic [`DDRMB_SY_W-1:0] raw;
  logic [`DDRMB_SY_W-1:0] sy1_q;
  logic [`DDRMB_SY_W-1:0] sy2_q;
  logic [`DDRMB_SY_W-1:0] sy3_q;
  logic [`DDRMB_SY_W-1:0] flt_q;
  logic [`DDRMB_SY_W-1:0] flt_d;
  logic                   ck_lvl_q;
  logic                   ck_lvl_d;
  logic                   psc_lvl_q;
  logic                   psc_lvl_d;
  logic                   ck_edge;
  logic                   ck_rise;
  logic                   psc_edge;
  logic                   strobe_edge;
  logic                   active;
  logic                   cs_prev_q;
  logic [7:0]             dq_s;
  ddrmb_state_t           st_q;
  logic [2:0]             ca_cnt_q;
  logic [47:0]            ca_q;
  logic [47:0]            ca_next;
  logic [LW-1:0]          lat_cnt_q;
  logic                   is_rd_q;
  logic [AW-1:0]          addr_q;
  logic [7:0]             mem_q [MEM_BYTES];
  logic                   ca_done;
  logic                   fill_ready;
  logic                   fill_valid;
  logic [7:0]             pop_data;
  logic                   pop_valid;
  logic                   pop;
  logic [7:0]             dq_out_q;
  logic                   dq_oe_n_q;
  logic                   rw_data_strobe_q;
  logic                   rw_data_strobe_oe_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // every pin from the host passes three flops; a level counts once the
  // second and third stage agree, which rejects a single metastable sample
  assign raw = {dq_in, rw_data_strobe_in, shifted_clk_n, shifted_clk_p,
                bus_clk_n, bus_clk_p, cs_n, hw_reset_n};

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sy1_q <= `DDRMB_SY_INIT;
      sy2_q <= `DDRMB_SY_INIT;
      sy3_q <= `DDRMB_SY_INIT;
      flt_q <= `DDRMB_SY_INIT;
    end
    else if (ce)
    begin
      sy1_q <= raw;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      flt_q <= flt_d;
    end
  end

  // per-bit agreement filter
  for (genvar gi = 0; gi < `DDRMB_SY_W; gi++)
  begin : g_flt
    assign flt_d[gi] = (sy2_q[gi] == sy3_q[gi]) ? sy3_q[gi] : flt_q[gi];
  end

  assign active = flt_q[`DDRMB_SY_RSTN] && !flt_q[`DDRMB_SY_CSN];
  assign dq_s   = flt_q[`DDRMB_SY_DQ +: 8];

  ////////////////////////////////////////////////////////////////////////////
  // clock levels: in differential mode a level only changes at a crossing,
  // so while both lines read alike the old level holds
  always_comb
  begin
    ck_lvl_d  = ck_lvl_q;
    psc_lvl_d = psc_lvl_q;
    if (!diff_clk_mode ||
        (flt_q[`DDRMB_SY_CKP] != flt_q[`DDRMB_SY_CKN]))
    begin
      ck_lvl_d = flt_q[`DDRMB_SY_CKP];
    end
    if (!diff_clk_mode ||
        (flt_q[`DDRMB_SY_PSCP] != flt_q[`DDRMB_SY_PSCN]))
    begin
      psc_lvl_d = flt_q[`DDRMB_SY_PSCP];
    end
  end

  // edges only, never periods: a stopped clock simply yields no edge
  assign ck_edge  = (ck_lvl_d != ck_lvl_q);
  assign ck_rise  = ck_edge && ck_lvl_d;
  assign psc_edge = (psc_lvl_d != psc_lvl_q);
  // shifted clock only matters in a read; in writes it is ignored
  assign strobe_edge = (st_q == DDRMB_RD) &&
                       (center_aligned_read_strobe ? psc_edge : ck_edge);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ck_lvl_q  <= 1'b0;
      psc_lvl_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end
    else if (ce)
    begin
      ck_lvl_q  <= ck_lvl_d;
      psc_lvl_q <= psc_lvl_d;
      cs_prev_q <= flt_q[`DDRMB_SY_CSN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transaction sequencer
  assign ca_next = {ca_q[39:0], dq_s};
  assign ca_done = (st_q == DDRMB_CA) && ck_edge &&
                   (ca_cnt_q == `DDRMB_CA_BYTES - 3'd1);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q      <= DDRMB_IDLE;
      ca_cnt_q  <= 3'h0;
      ca_q      <= 48'h0;
      lat_cnt_q <= '0;
      is_rd_q   <= 1'b0;
    end
    else if (ce)
    begin
      if (!active)
      begin
        st_q <= DDRMB_IDLE;
      end
      else
      begin
        case (st_q)
          DDRMB_IDLE:
          begin
            // only a real high-to-low select starts a transaction
            if (cs_prev_q)
            begin
              st_q     <= DDRMB_CA;
              ca_cnt_q <= 3'h0;
            end
          end
          DDRMB_CA:
          begin
            // both clock edges carry a byte on the shared bus
            if (ck_edge)
            begin
              ca_q     <= ca_next;
              ca_cnt_q <= ca_cnt_q + 3'd1;
            end
            if (ca_done)
            begin
              st_q      <= DDRMB_LAT;
              lat_cnt_q <= '0;
              is_rd_q   <= ca_next[`DDRMB_CA_RD_BIT];
            end
          end
          DDRMB_LAT:
          begin
            // latency is always the doubled count
            if (ck_rise)
            begin
              lat_cnt_q <= lat_cnt_q + 1'b1;
              if (lat_cnt_q == LW'(LAT_TOTAL - 1))
              begin
                st_q <= is_rd_q ? DDRMB_RD : DDRMB_WR;
              end
            end
          end
          DDRMB_RD, DDRMB_WR, DDRMB_DONE:
          begin
            st_q <= st_q; // held until select rises
          end
          default:
          begin
            st_q <= DDRMB_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address and array: writes land straight from the bus, reads prefetch
  // into the fifo so a pop on a bus edge never waits on the array
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      addr_q <= '0;
    end
    else if (ce)
    begin
      if (ca_done)
      begin
        addr_q <= ca_next[AW-1:0];
      end
      else if ((st_q == DDRMB_WR && ck_edge) || (fill_valid && fill_ready))
      begin
        addr_q <= addr_q + 1'b1;
      end
    end
  end

  // host strobe high masks the byte on that edge
  always_ff @(posedge ref_clk)
  begin
    if (ce && active && st_q == DDRMB_WR && ck_edge &&
        !flt_q[`DDRMB_SY_RW_DATA_STROBE])
    begin
      mem_q[addr_q] <= dq_s;
    end
  end

  // prefetch stalls whenever the fifo reports full
  assign fill_valid = active && is_rd_q &&
                      (st_q == DDRMB_LAT || st_q == DDRMB_RD);
  assign pop = (st_q == DDRMB_RD) && ck_edge;

  ddrmb_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .ce        (ce),
    .flush     (st_q == DDRMB_IDLE),
    .in_data   (mem_q[addr_q]),
    .in_valid  (fill_valid),
    .in_ready  (fill_ready),
    .out_data  (pop_data),
    .out_valid (pop_valid),
    .out_ready (pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read data changes on main clock edges; strobe toggles on its own edge
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      dq_out_q <= 8'h00;
      rw_data_strobe_q   <= 1'b0;
    end
    else if (ce)
    begin
      if (pop && pop_valid)
      begin
        dq_out_q <= pop_data;
      end
      if (st_q == DDRMB_CA)
      begin
        rw_data_strobe_q <= 1'b1; // extra latency always flagged
      end
      else if (st_q == DDRMB_LAT)
      begin
        rw_data_strobe_q <= 1'b0;
      end
      else if (strobe_edge)
      begin
        rw_data_strobe_q <= !rw_data_strobe_q;
      end
    end
  end

  // enables are low while driving; release on select high or reset pin low
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      dq_oe_n_q   <= 1'b1;
      rw_data_strobe_oe_n_q <= 1'b1;
    end
    else if (ce)
    begin
      dq_oe_n_q   <= !(active && st_q == DDRMB_RD);
      rw_data_strobe_oe_n_q <= !(active && (st_q == DDRMB_CA ||
                       (st_q == DDRMB_LAT && is_rd_q) ||
                       st_q == DDRMB_RD));
    end
  end

  assign dq_out              = dq_out_q;
  assign dq_oe_n             = dq_oe_n_q;
  assign rw_data_strobe_out  = rw_data_strobe_q;
  assign rw_data_strobe_oe_n = rw_data_strobe_oe_n_q;

endmodule : ddrmb_device

// ### verif/ddrmb_sva.sv
module ddrmb_sva (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       center_aligned_read_strobe,
  input wire logic       hw_reset_n,
  input wire logic       cs_n,
  input wire logic       bus_clk_p,
  input wire logic       shifted_clk_p,
  input wire logic [7:0] dq_out,
  input wire logic       dq_oe_n,
  input wire logic       rw_data_strobe_out,
  input wire logic       rw_data_strobe_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // cycles since the bus clock pin last moved, saturating at 15
  logic [3:0] since_q;
  logic       ckp_q;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      since_q <= 4'h0;
      ckp_q   <= 1'b0;
    end
    else
    begin
      ckp_q   <= bus_clk_p;
      since_q <= (ckp_q != bus_clk_p) ? 4'h0 :
                 since_q + {3'h0, since_q != 4'hF};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  idle_float_a: assert property (
    cs_n [*8] |-> dq_oe_n && rw_data_strobe_oe_n)
    else $error("outputs driven while deselected");
  cs_release_a: assert property (
    $rose(cs_n) |-> ##[1:8] (dq_oe_n && rw_data_strobe_oe_n))
    else $error("outputs kept after deselect");
  hw_float_a: assert property (
    !hw_reset_n [*8] |-> dq_oe_n && rw_data_strobe_oe_n)
    else $error("outputs driven in hardware reset");
  start_flag_a: assert property (
    $fell(cs_n) && hw_reset_n |->
      ##[3:10] (!rw_data_strobe_oe_n && rw_data_strobe_out))
    else $error("no latency flag at start");
  read_pair_a: assert property (
    !dq_oe_n |-> !rw_data_strobe_oe_n)
    else $error("data driven without strobe");
  // read strobe moves only a few cycles after its reference clock pin
  center_edge_a: assert property (
    center_aligned_read_strobe && !dq_oe_n && !$past(dq_oe_n) &&
    $changed(rw_data_strobe_out) |->
      $past(shifted_clk_p, 2) != $past(shifted_clk_p, 8))
    else $error("strobe not timed by shifted clock");
  bus_edge_a: assert property (
    !center_aligned_read_strobe && !dq_oe_n && !$past(dq_oe_n) &&
    $changed(rw_data_strobe_out) |->
      $past(bus_clk_p, 2) != $past(bus_clk_p, 8))
    else $error("strobe not timed by bus clock");
  dq_edge_a: assert property (
    !dq_oe_n && !$past(dq_oe_n) && $changed(dq_out) |->
      since_q inside {[4'h2:4'h7]})
    else $error("read data moved without a clock edge");
endmodule : ddrmb_sva

bind ddrmb_device ddrmb_sva u_sva (
  .ref_clk(ref_clk),
  .rst(rst),
  .center_aligned_read_strobe(center_aligned_read_strobe),
  .hw_reset_n(hw_reset_n),
  .cs_n(cs_n),
  .bus_clk_p(bus_clk_p),
  .shifted_clk_p(shifted_clk_p),
  .dq_out(dq_out),
  .dq_oe_n(dq_oe_n),
  .rw_data_strobe_out(rw_data_strobe_out),
  .rw_data_strobe_oe_n(rw_data_strobe_oe_n)
);

// ### verif/ddrmb_host.sv
module ddrmb_host #(
  parameter int LAT = 2
) (
  input  wire logic       ref_clk,
  input  wire logic       diff,
  input  wire logic [7:0] dq_bus,
  output logic            cs_n,
  output logic            bus_clk_p,
  output logic            bus_clk_n,
  output logic            shifted_clk_p,
  output logic            shifted_clk_n,
  output logic [7:0]      host_dq,
  output logic            host_dq_en,
  output logic            host_strobe,
  output logic            host_strobe_en
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [3:0]  wmsk;
  int          stall;

  // deselected with every clock parked low
  initial
  begin
    cs_n = 1'b1;
    bus_clk_p = 1'b0;
    bus_clk_n = 1'b1;
    shifted_clk_p = 1'b0;
    shifted_clk_n = 1'b0;
    host_dq = 8'h00;
    host_dq_en = 1'b0;
    host_strobe = 1'b0;
    host_strobe_en = 1'b0;
    stall = 0;
  end

  // one bus edge, shifted clock four ref_clk cycles behind
  task automatic edge_t(input logic wr, output logic [7:0] smp);
    repeat (stall + 4) @(posedge ref_clk); // pauses gate the clock
    smp = dq_bus;
    bus_clk_p <= ~bus_clk_p;
    bus_clk_n <= diff ? bus_clk_p : 1'b1;
    repeat (4) @(posedge ref_clk);
    if (!wr)
      shifted_clk_p <= ~shifted_clk_p;     // static in writes
    shifted_clk_n <= diff & (wr ? ~shifted_clk_p : shifted_clk_p);
  endtask : edge_t

  // whole transaction; clocks are parked low while select is still high,
  // since an odd edge count leaves the bus clock high at the end
  task automatic xfer(input logic rd, input logic [3:0] a, input int n);
    logic [7:0] smp;
    bus_clk_p <= 1'b0;
    bus_clk_n <= 1'b1;
    shifted_clk_p <= 1'b0;
    shifted_clk_n <= diff;
    repeat (8) @(posedge ref_clk);         // park settles before select
    cs_n <= 1'b0;
    host_dq_en <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      host_dq <= (i == 0) ? {rd, 7'h00} : (i == 5) ? {4'h0, a} : 8'h00;
      edge_t(!rd, smp);
    end
    host_dq_en <= !rd;
    // the last latency count is a rising edge; data starts on the next edge
    for (int i = 0; i < 4 * LAT - 1; i++)
      edge_t(!rd, smp);                    // doubled latency always
    host_strobe_en <= !rd;
    for (int i = 0; i < n; i++)
    begin
      host_dq <= wdat[31 - 8 * i -: 8];
      host_strobe <= wmsk[3 - i];          // high masks the byte
      edge_t(!rd, smp);
      if (i > 0)
        rdat[39 - 8 * i -: 8] = smp;
    end
    repeat (8) @(posedge ref_clk);
    rdat[39 - 8 * n -: 8] = dq_bus;
    host_dq_en <= 1'b0;
    host_strobe_en <= 1'b0;
    cs_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask : xfer
endmodule : ddrmb_host

// ### verif/ddr_memory_bus_center_strobe_tb_top.sv
module ddr_memory_bus_center_strobe_tb_top import ddrmb_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic       ref_clk, rst, diff, center, hw_reset_n, tgl_q;
  logic       cs_n, ck_p, ck_n, sc_p, sc_n, h_en, h_st, h_st_en;
  logic       dq_oe_n, st_out, st_oe_n, st_in;
  logic [7:0] h_dq, dq_out, dq_in;
  int         n_errors, checks_done;

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // released lines carry a moving pattern, never a held value
  always @(posedge ref_clk)
    tgl_q <= ~tgl_q;
  assign dq_in = !dq_oe_n ? dq_out : h_en ? h_dq : {8{tgl_q}};
  assign st_in = !st_oe_n ? st_out : h_st_en ? h_st : tgl_q;

  ddrmb_device #(.LAT_CLKS(2)) DUT (.ref_clk(ref_clk), .rst(rst),
    .ce(1'b1), .diff_clk_mode(diff), .center_aligned_read_strobe(center),
    .hw_reset_n(hw_reset_n), .cs_n(cs_n), .bus_clk_p(ck_p),
    .bus_clk_n(ck_n), .shifted_clk_p(sc_p), .shifted_clk_n(sc_n),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .rw_data_strobe_in(st_in), .rw_data_strobe_out(st_out),
    .rw_data_strobe_oe_n(st_oe_n));
  ddrmb_host #(.LAT(2)) host (.ref_clk(ref_clk), .diff(diff),
    .dq_bus(dq_in), .cs_n(cs_n), .bus_clk_p(ck_p), .bus_clk_n(ck_n),
    .shifted_clk_p(sc_p), .shifted_clk_n(sc_n), .host_dq(h_dq),
    .host_dq_en(h_en), .host_strobe(h_st), .host_strobe_en(h_st_en));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  // writes wrap past the top; a masked byte keeps its old value
  task automatic t_write_read;
    host.wdat = 32'hA1B2C3D4;
    host.wmsk = 4'h0;
    host.xfer(1'b0, 4'hE, 4);
    host.wdat = 32'h11220000;
    host.wmsk = 4'h4;
    host.xfer(1'b0, 4'hF, 2);
    host.xfer(1'b1, 4'hE, 4);
    chk(host.rdat[31:24], 8'hA1);
    chk(host.rdat[23:16], 8'h11);
    chk(host.rdat[15:8], 8'hC3);
    chk(host.rdat[7:0], 8'hD4);
    chk({6'h00, dq_oe_n, st_oe_n}, 8'h03);
  endtask : t_write_read

  // differential clocks with long pauses between edges
  task automatic t_diff_gated;
    diff <= 1'b1;
    center <= 1'b0;
    host.stall = 30;
    @(posedge ref_clk);
    host.xfer(1'b1, 4'h0, 2);
    chk(host.rdat[31:24], 8'hC3);
    chk(host.rdat[23:16], 8'hD4);
  endtask : t_diff_gated

  // reset pin mid-read floats the outputs; a fresh select works again
  task automatic t_hw_reset;
    diff <= 1'b0;
    center <= 1'b1;
    host.stall = 10;
    fork
      host.xfer(1'b1, 4'hE, 2);
      begin
        repeat (60) @(posedge ref_clk);
        chk({6'h00, st_oe_n, st_out}, 8'h01);
        repeat (208) @(posedge ref_clk);
        chk({6'h00, dq_oe_n, st_oe_n}, 8'h00);
        hw_reset_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        chk({6'h00, dq_oe_n, st_oe_n}, 8'h03);
        hw_reset_n <= 1'b1;
      end
    join
    host.stall = 0;
    host.xfer(1'b1, 4'hE, 2);
    chk(host.rdat[31:24], 8'hA1);
  endtask : t_hw_reset

  initial
  begin
    rst = 1'b1;
    diff = 1'b0;
    center = 1'b1;
    hw_reset_n = 1'b1;
    tgl_q = 1'b0;
    n_errors = 0;
    checks_done = 0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk({6'h00, dq_oe_n, st_oe_n}, 8'h03);
    t_write_read();
    t_diff_gated();
    t_hw_reset();
    test_done();
  end

  // watchdog, well past the roughly 1500 cycles the tests need
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    test_done();
  end
endmodule : ddr_memory_bus_center_strobe_tb_top
